/* common/adc_link_if.sv */
/*
 * the serial and auxiliary pins between host and converter.
 * assumes the bench resolves shared wires from the enables.
 */
`timescale 1ns/1ps
interface adc_link_if;
    logic serial_clock;
    logic chip_select_b;
    logic serial_in;
    logic serial_out;
    logic serial_out_en;
    logic sync_in_b;
    logic aux_pin_one;
    logic aux_pin_two_out;
    logic aux_pin_two_en;
    logic aux_pin_two_in;
    modport device (
        input serial_clock, chip_select_b, serial_in, sync_in_b, aux_pin_two_in,
        output serial_out, serial_out_en, aux_pin_one, aux_pin_two_out, aux_pin_two_en
    );
    modport host (
        output serial_clock, chip_select_b, serial_in, sync_in_b, aux_pin_two_in,
        input serial_out, serial_out_en, aux_pin_one, aux_pin_two_out, aux_pin_two_en
    );
endinterface : adc_link_if

/* common/adc_link_params.svh */
/*
 * timing counts, field positions and reset values shared by both ends.
 * assumes inclusion by bare name from common/.
 */
`ifndef ADC_LINK_PARAMS_SVH
`define ADC_LINK_PARAMS_SVH
`define WORD_BITS 24
`define ADDR_BITS 7
`define CMD_READ_BIT 7
`define CONV_PERIOD 40
`define CHAN_COUNT 4
`define SCLK_DIV 2
`define CTL_ADDR_MODE 7'h01
`define CTL_ADDR_DAC 7'h02
`define CTL_ADDR_GPIO 7'h03
`define CTL_ADDR_DATA 7'h10
`define MODE_RESET 16'h0000
`define HOST_REG_CMD 4'h0
`define HOST_REG_WDATA 4'h1
`define HOST_REG_STATUS 4'h2
`define HOST_REG_RDATA 4'h3
`endif

/* common/adc_link_pkg.sv */
/*
 * types used by the converter end and the bench; the host end does not use them.
 * assumes adc_link_params.svh is on the include path.
 */
package adc_link_pkg;
    typedef enum logic [1:0] {
        clk_int_quiet,
        clk_int_out,
        clk_ext_in,
        clk_crystal
    } clock_source_t;
    typedef enum logic [1:0] {
        exc_off,
        exc_two_wire,
        exc_four_wire,
        exc_spare
    } excitation_t;
endpackage : adc_link_pkg

/* logic/adc_device_end.sv */
/*
 * converter end: serial port, data ready, streaming, sync and pin muxing.
 * assumes serial_clock is the link clock, idle high, and the main clock is clock.
 */
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "adc_link_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - default sync low resets sequence, restarts first
// - alternate sync waits for sync high after change
// - active-low select; tied low keeps output driven
// - continuous or burst serial clock both work
// - shift out on falling edge, host samples rising
// - output low on ready, high before next update
// - ready may go to aux pin one
// - streaming drives clock, frame, results automatically
// - stream clock on aux two, ready aux one
// - input shift register loads addressed control register
// - clock select picks one of four sources
// - start on aux two gives resynchronised sync out
// - rising start on aux two may strobe dac load
// - excitation drives general pins three, four or all
// - each general pin input or output
// - default sync low holds filter, calibration, modulator reset
// - sync leaves interface, forces ready high
// - data read releases ready; continuous read once
module adc_device_end (
    // main clock domain
    input wire logic clock,
    input wire logic rst_b,
    // link
    adc_link_if.device link,
    // converter side
    input wire logic [`WORD_BITS-1:0] conv_result,
    input wire logic [3:0] gpio_in,
    output logic [3:0] gpio_out,
    output logic [3:0] gpio_oe,
    output logic [1:0] chan_index,
    output logic core_reset,
    output logic sync_out,
    output logic dac_load,
    output logic [1:0] clock_source_select,
    output logic [15:0] dac_value
);
    // mode bits: 0 rdy on aux1, 1 stream, 2 alternate_sync_mode, 3 multi sync, 4 dac strobe,
    // 5 continuous read, 7:6 clock source, 9:8 excitation
    typedef struct packed {
        logic [15:0] mode;
        logic [15:0] dac_reg;
        logic [7:0] gpio_reg;
        logic [`WORD_BITS-1:0] data;
        logic ready;
        logic read_once;
        logic [7:0] conv_cnt;
        logic [1:0] chan;
        logic waiting;
        logic [2:0] start_hist;
        logic sync_out;
        logic dac_load;
        logic rd_tgl_seen;
        logic phase;
        logic [`WORD_BITS-1:0] stream_sh;
        logic [4:0] stream_cnt;
        logic stream_clk;
        logic [1:0] div;
    } main_t;
    typedef struct packed {
        logic [31:0] in_sh;
        logic [`WORD_BITS-1:0] out_sh;
        logic wr_tgl;
        logic rd_tgl;
        logic [`ADDR_BITS-1:0] addr;
        logic [15:0] wdata;
    } link_t;

    main_t r, next_r;
    link_t l, next_l;
    logic sync_low, start_s;
    logic [5:0] frame_bits;
    logic [15:0] wdata_s;
    logic [`ADDR_BITS-1:0] addr_s;
    logic wr_s, rd_s, out_q;

    sync_two_ff #(.WIDTH(1)) u_sync (.clock(clock), .rst_b(rst_b),
        .din(~link.sync_in_b), .dout(sync_low));
    sync_two_ff #(.WIDTH(1)) u_start (.clock(clock), .rst_b(rst_b),
        .din(link.aux_pin_two_in), .dout(start_s));
    sync_two_ff #(.WIDTH(2)) u_tgl (.clock(clock), .rst_b(rst_b),
        .din({l.wr_tgl, l.rd_tgl}), .dout({wr_s, rd_s}));
    // address and data stand still long before the toggle arrives
    assign wdata_s = l.wdata;
    assign addr_s = l.addr;

    ////////////////////////////////////////////////////////////////////////////
    // link domain: shifting on the serial clock, works for bursts too
    always_comb begin
        next_l = l;
        if (!link.chip_select_b) begin
            next_l.in_sh = {l.in_sh[30:0], link.serial_in};
            if (frame_bits == 6'h07 && l.in_sh[6]) begin
                next_l.addr = {l.in_sh[5:0], link.serial_in};
                next_l.out_sh = r.data;
                if ({l.in_sh[5:0], link.serial_in} == `CTL_ADDR_DATA) begin
                    next_l.rd_tgl = ~l.rd_tgl;
                end
            end
            if (frame_bits == 6'h17 && !l.in_sh[22]) begin
                next_l.addr = l.in_sh[21:15];
                next_l.wdata = {l.in_sh[14:0], link.serial_in};
                next_l.wr_tgl = ~l.wr_tgl;
            end
        end
    end

    // bit counter of the frame; the serial clock idles, so deselect clears it
    always_ff @(posedge link.serial_clock or posedge link.chip_select_b) begin
        if (link.chip_select_b) begin
            frame_bits <= 6'h00;
        end else begin
            frame_bits <= frame_bits + 6'h01;
        end
    end

    always_ff @(posedge link.serial_clock or negedge rst_b) begin
        if (!rst_b) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    // output bit changes on the falling edge, held stable for the rising
    always_ff @(negedge link.serial_clock or negedge rst_b) begin
        if (!rst_b) begin
            out_q <= 1'b1;
        end else begin
            if (frame_bits >= 6'h08 && frame_bits < 6'(`WORD_BITS + 8)) begin
                out_q <= l.out_sh[`WORD_BITS - 1 - (frame_bits - 6'h08)];
            end else begin
                out_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // main domain
    always_comb begin
        next_r = r;
        next_r.start_hist = {r.start_hist[1:0], start_s};
        next_r.dac_load = 1'b0;
        next_r.rd_tgl_seen = rd_s;
        next_r.phase = wr_s;
        if (wr_s != r.phase) begin
            unique case (addr_s)
                `CTL_ADDR_MODE: next_r.mode = wdata_s;
                `CTL_ADDR_DAC: next_r.dac_reg = wdata_s;
                `CTL_ADDR_GPIO: next_r.gpio_reg = wdata_s[7:0];
                default: ;
            endcase
        end
        if (rd_s != r.rd_tgl_seen) begin
            next_r.ready = 1'b1;
            next_r.read_once = r.mode[5];
        end
        // conversion pacing and channel sequence
        if (sync_low && !r.mode[2]) begin
            next_r.conv_cnt = 8'h00;
            next_r.chan = 2'h0;
            next_r.ready = 1'b1;
        end else if (r.waiting) begin
            next_r.waiting = sync_low;
            if (sync_low) next_r.ready = 1'b1;
        end else if (r.conv_cnt == 8'(`CONV_PERIOD - 1)) begin
            next_r.conv_cnt = 8'h00;
            next_r.data = conv_result;
            next_r.ready = 1'b0;
            next_r.read_once = 1'b0;
            next_r.chan = r.chan + 2'h1;
            next_r.waiting = r.mode[2];
            if (r.mode[1]) begin
                next_r.stream_sh = conv_result;
                next_r.stream_cnt = 5'(`WORD_BITS);
            end
        end else begin
            next_r.conv_cnt = r.conv_cnt + 8'h01;
            if (r.conv_cnt == 8'(`CONV_PERIOD - 2)) next_r.ready = 1'b1;
        end
        // streaming clock from main clock divider
        next_r.div = r.div + 2'h1;
        if (r.stream_cnt != 5'h00 && r.div == 2'h3) begin
            next_r.stream_clk = ~r.stream_clk;
            if (r.stream_clk) begin
                next_r.stream_sh = {r.stream_sh[`WORD_BITS-2:0], 1'b0};
                next_r.stream_cnt = r.stream_cnt - 5'h01;
            end
        end
        if (r.stream_cnt == 5'h00) next_r.stream_clk = 1'b0;
        // multi-device start resynchronised to main clock
        next_r.sync_out = r.mode[3] ? r.start_hist[2] : 1'b1;
        if (r.mode[4] && r.start_hist[1] && !r.start_hist[2]) next_r.dac_load = 1'b1;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
            r.mode <= `MODE_RESET;
            r.ready <= 1'b1;
            r.sync_out <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin muxing
    logic rdy_eff;
    assign rdy_eff = r.ready | r.read_once;
    always_comb begin
        if (r.mode[1]) begin
            link.serial_out = r.stream_sh[`WORD_BITS-1];
            link.serial_out_en = 1'b1;
        end else if (!link.chip_select_b) begin
            // tied-low select keeps the pin driven
            link.serial_out = (frame_bits == 6'h00 && !r.mode[0]) ? rdy_eff : out_q;
            link.serial_out_en = 1'b1;
        end else begin
            link.serial_out = 1'b1;
            link.serial_out_en = 1'b0;
        end
    end
    assign link.aux_pin_one = (r.mode[0] | r.mode[1]) ? rdy_eff : r.sync_out;
    assign link.aux_pin_two_out = r.stream_clk;
    assign link.aux_pin_two_en = r.mode[1];

    always_comb begin
        unique case (adc_link_pkg::excitation_t'(r.mode[9:8]))
            adc_link_pkg::exc_two_wire: begin
                gpio_oe = {2'b11, r.gpio_reg[5:4]};
                gpio_out = {~r.chan[0], r.chan[0], r.gpio_reg[1:0]};
            end
            adc_link_pkg::exc_four_wire: begin
                gpio_oe = 4'hf;
                gpio_out = {~r.chan[0], r.chan[0], ~r.chan[0], r.chan[0]};
            end
            default: begin
                gpio_oe = r.gpio_reg[7:4];
                gpio_out = r.gpio_reg[3:0];
            end
        endcase
    end
    assign chan_index = r.chan;
    assign core_reset = sync_low & ~r.mode[2];
    assign sync_out = r.sync_out;
    assign dac_load = r.dac_load;
    assign clock_source_select = r.mode[7:6];
    assign dac_value = r.dac_reg;
endmodule : adc_device_end

/* logic/adc_host_end.sv */
/*
 * host end: spi master with a small register port for software.
 * assumes clock is the host system clock; serial clock derived by divider.
 */
`timescale 1ns/1ps
`include "adc_link_params.svh"
module adc_host_end (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // link
    adc_link_if.host link,
    // software port
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // sync control
    input wire logic sync_req_b,
    input wire logic start_req
);
    typedef struct packed {
        logic [31:0] rdata;
        logic [31:0] cmd;
        logic [31:0] sh;
        logic [`WORD_BITS-1:0] rx;
        logic [5:0] left;
        logic busy;
        logic sclk;
        logic cs_b;
        logic [1:0] div;
        logic sync_b;
        logic start;
        logic fresh;
    } host_t;
    host_t r, next_r;
    logic sdo_s, rdy_s;
    sync_two_ff #(.WIDTH(2)) u_in (.clock(clock), .rst_b(rst_b),
        .din({link.serial_out, link.aux_pin_one}), .dout({sdo_s, rdy_s}));

    always_comb begin
        next_r = r;
        next_r.sync_b = sync_req_b;
        next_r.start = start_req;
        next_r.rdata = 32'h0;
        if (wr && addr == `HOST_REG_CMD && !r.busy) begin
            // cmd[31:24] instruction, [23:0] payload, bit 31 read
            next_r.sh = wdata;
            next_r.left = wdata[`CMD_READ_BIT + 24] ? 6'h20 : 6'h18;
            next_r.busy = 1'b1;
            next_r.cs_b = 1'b0;
            next_r.fresh = 1'b1;
            next_r.div = 2'h0;
        end
        if (rd) begin
            unique case (addr)
                `HOST_REG_STATUS: next_r.rdata = {30'h0, rdy_s, r.busy};
                `HOST_REG_RDATA: next_r.rdata = {8'h0, r.rx};
                default: next_r.rdata = 32'h0;
            endcase
        end
        if (r.busy) begin
            next_r.div = r.div + 2'h1;
            if (r.div == 2'(`SCLK_DIV - 1)) begin
                next_r.div = 2'h0;
                next_r.sclk = ~r.sclk;
                if (r.sclk) begin
                    // bit that stood at the last rising edge, after the synchroniser
                    next_r.rx = {r.rx[`WORD_BITS-2:0], sdo_s};
                    // data in moves on falling edges only; the first bit already stands
                    next_r.fresh = 1'b0;
                    if (!r.fresh) begin
                        next_r.sh = {r.sh[30:0], 1'b0};
                    end
                    if (r.left == 6'h00) begin
                        next_r.busy = 1'b0;
                        next_r.cs_b = 1'b1;
                        next_r.sclk = 1'b1;
                    end
                end else begin
                    next_r.left = r.left - 6'h01;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
            r.sclk <= 1'b1;
            r.cs_b <= 1'b1;
            r.sync_b <= 1'b1;
        end else begin
            r <= next_r;
        end
    end
    assign link.serial_clock = r.sclk;
    assign link.chip_select_b = r.cs_b;
    assign link.serial_in = r.sh[31];
    assign link.sync_in_b = r.sync_b;
    assign link.aux_pin_two_in = r.start;
    assign rdata = r.rdata;
endmodule : adc_host_end

/* logic/sync_two_ff.sv */
/*
 * two flip-flop level synchroniser.
 * assumes the input is a level from another domain.
 */
`timescale 1ns/1ps
module sync_two_ff #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // level crossing
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule : sync_two_ff

/* tb/adc_link_chk.sv */
/*
 * concurrent checks on the serial link between host end and converter end.
 * assumes it is instantiated beside the interface with its signals by name.
 */
`timescale 1ns/1ps
module adc_link_chk (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // link
    input wire logic serial_clock,
    input wire logic chip_select_b,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_en,
    input wire logic sync_in_b,
    input wire logic aux_pin_two_en
);
    logic [7:0] edges;
    logic [7:0] base;

    ////////////////////////////////////////////////////////////////////////////////
    // falling edges of serial clock per frame
    always_ff @(negedge serial_clock or negedge rst_b) begin
        if (!rst_b) begin
            edges <= 8'h00;
        end else if (!chip_select_b) begin
            edges <= edges + 8'h01;
        end
    end

    always_ff @(negedge chip_select_b or negedge rst_b) begin
        if (!rst_b) begin
            base <= 8'h00;
        end else begin
            base <= edges;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions
    release_idle_a: assert property (@(posedge clock) disable iff (!rst_b)
        (chip_select_b && !aux_pin_two_en) [*2] |-> !serial_out_en)
        else $error("serial output driven while deselected");
    select_drive_a: assert property (@(posedge clock) disable iff (!rst_b)
        !chip_select_b [*4] |-> serial_out_en)
        else $error("serial output not driven while selected");
    shift_fall_a: assert property (@(posedge clock) disable iff (!rst_b)
        (!chip_select_b && serial_clock && (edges != base)) [*2] |-> $stable(serial_out))
        else $error("serial output moved while serial clock high");
    input_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
        (!chip_select_b && serial_clock) [*2] |-> $stable(serial_in))
        else $error("serial input moved while serial clock high");
    clock_idle_a: assert property (@(posedge clock) disable iff (!rst_b)
        chip_select_b [*2] |-> serial_clock)
        else $error("serial clock not idle high outside frame");
    frame_start_a: assert property (@(posedge clock) disable iff (!rst_b)
        $fell(chip_select_b) |-> serial_clock)
        else $error("frame opened with serial clock low");
    frame_end_a: assert property (@(posedge clock) disable iff (!rst_b)
        $rose(chip_select_b) |-> serial_clock)
        else $error("frame closed with serial clock low");
    frame_len_a: assert property (@(posedge chip_select_b) disable iff (!rst_b)
        (edges - base == 8'h18) || (edges - base == 8'h20))
        else $error("frame length neither 24 nor 32 clocks");

    write_frame_c: cover property (@(posedge chip_select_b) (edges - base) == 8'h18);
    read_frame_c: cover property (@(posedge chip_select_b) (edges - base) == 8'h20);
    sync_low_c: cover property (@(posedge clock) $fell(sync_in_b));
endmodule : adc_link_chk

/* tb/tb.sv */
/*
 * bench joining host end and converter end over the link interface.
 * assumes the host clock at 25 MHz and an unrelated 48 ns converter clock.
 */
`timescale 1ns/1ps
`include "adc_link_params.svh"
module tb;
    typedef struct packed {
        logic [7:0] instr;
        logic [15:0] wd;
        logic [23:0] conv;
        logic [23:0] exp;
    } row_t;

    logic clock = 1'b0;
    logic link_clock = 1'b0;
    logic rst_b;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic sync_req_b = 1'b1;
    logic start_req = 1'b0;
    logic [23:0] conv_result = 24'h0;
    logic [3:0] gpio_in = 4'h5;
    logic [3:0] gpio_out;
    logic [3:0] gpio_oe;
    logic [1:0] chan_index;
    logic core_reset;
    logic sync_out;
    logic dac_load;
    logic [1:0] clock_source_select;
    logic [15:0] dac_value;
    logic [31:0] got;
    int errors = 0;
    int cmp_count = 0;
    row_t rows [5] = '{
        '{{1'b0, `CTL_ADDR_DAC}, 16'h0000, 24'h000000, 24'h000000},
        '{{1'b0, `CTL_ADDR_DAC}, 16'hffff, 24'h000000, 24'h00ffff},
        '{{1'b0, `CTL_ADDR_DAC}, 16'ha5c3, 24'h000000, 24'h00a5c3},
        '{{1'b1, `CTL_ADDR_DATA}, 16'h0000, 24'h123456, 24'h123456},
        '{{1'b1, `CTL_ADDR_DATA}, 16'h0000, 24'hfedcba, 24'hfedcba}
    };

    always #20 clock = ~clock;
    initial begin
        #7;
        forever #24 link_clock = ~link_clock;
    end

    adc_link_if adc_link_if_inst ();
    adc_host_end adc_host_end_inst (
        .clock(clock), .rst_b(rst_b), .link(adc_link_if_inst.host),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .sync_req_b(sync_req_b), .start_req(start_req)
    );
    adc_device_end adc_device_end_inst (
        .clock(link_clock), .rst_b(rst_b), .link(adc_link_if_inst.device),
        .conv_result(conv_result), .gpio_in(gpio_in), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .chan_index(chan_index), .core_reset(core_reset),
        .sync_out(sync_out), .dac_load(dac_load),
        .clock_source_select(clock_source_select), .dac_value(dac_value)
    );
    adc_link_chk adc_link_chk_inst (
        .clock(link_clock), .rst_b(rst_b),
        .serial_clock(adc_link_if_inst.serial_clock),
        .chip_select_b(adc_link_if_inst.chip_select_b),
        .serial_in(adc_link_if_inst.serial_in),
        .serial_out(adc_link_if_inst.serial_out),
        .serial_out_en(adc_link_if_inst.serial_out_en),
        .sync_in_b(adc_link_if_inst.sync_in_b),
        .aux_pin_two_en(adc_link_if_inst.aux_pin_two_en)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // software port and checks
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check

    // one strobe cycle, then one idle cycle
    task automatic sw_write(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        @(posedge clock);
    endtask : sw_write

    task automatic sw_read(input logic [3:0] a, output logic [31:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        d = rdata;
        @(posedge clock);
    endtask : sw_read

    task automatic xfer(input logic [7:0] instr, input logic [15:0] wd);
        int n;
        logic [31:0] s;
        sw_write(`HOST_REG_CMD, {instr, wd, 8'h00});
        s = 32'h1;
        for (n = 0; n < 500 && s[0] !== 1'b0; n++) begin
            sw_read(`HOST_REG_STATUS, s);
        end
        check({31'h0, s[0]}, 32'h0);
    endtask : xfer

    task automatic wrap_up();
        if (errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst_b <= 1'b0;
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        repeat (4) @(posedge clock);
        check({31'h0, adc_link_if_inst.serial_out_en}, 32'h0);
        check({31'h0, adc_link_if_inst.chip_select_b}, 32'h1);
        for (int i = 0; i < 5; i++) begin
            conv_result <= rows[i].conv;
            repeat (60) @(posedge clock);
            xfer(rows[i].instr, rows[i].wd);
            if (rows[i].instr[7]) begin
                sw_read(`HOST_REG_RDATA, got);
                check({8'h00, got[23:0]}, {8'h00, rows[i].exp});
            end else begin
                repeat (4) @(posedge clock);
                check({16'h0000, dac_value}, {8'h00, rows[i].exp});
            end
        end
        // clock source and four-wire excitation through the mode register
        xfer({1'b0, `CTL_ADDR_MODE}, 16'h02c0);
        repeat (4) @(posedge clock);
        check({30'h0, clock_source_select}, {30'h0, adc_link_pkg::clk_crystal});
        check({28'h0, gpio_oe}, 32'h0000000f);
        // sync held low, then released
        sync_req_b <= 1'b0;
        repeat (20) @(posedge clock);
        check({31'h0, core_reset}, 32'h1);
        check({30'h0, chan_index}, 32'h0);
        sync_req_b <= 1'b1;
        repeat (3) @(posedge clock);
        check({30'h0, chan_index}, 32'h0);
        repeat (20) @(posedge clock);
        check({31'h0, core_reset}, 32'h0);
        wrap_up();
    end

    initial begin
        #400000;
        errors++;
        $display("Error at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        wrap_up();
    end
endmodule : tb
